// ===== mmit_defines.svh
`ifndef MMIT_DEFINES_SVH
`define MMIT_DEFINES_SVH

// Register byte addresses
`define MMIT_ADDR_CTRL      12'h000
`define MMIT_ADDR_REGION    12'h004
`define MMIT_ADDR_VGA_TRAP_CONTROL    12'h008
`define MMIT_ADDR_VGAMASK   12'h00C
`define MMIT_ADDR_STATUS    12'h010
`define MMIT_ADDR_HDRFLAGS  12'h014

// Control register fields
`define MMIT_CTRL_ENABLE    0
`define MMIT_CTRL_CODEACC   1

// Region register: base in [31:12], size code in [3:0]
`define MMIT_REG_SIZE_LSB   0
`define MMIT_REG_SIZE_W     4
`define MMIT_REG_BASE_LSB   12
`define MMIT_SIZE_MAX       4'hE

// VGA trap control bits
`define MMIT_VGA_A0         0
`define MMIT_VGA_B0         1
`define MMIT_VGA_B8         2
`define MMIT_VGA_IO3B       3
`define MMIT_VGA_IO3C       4
`define MMIT_VGA_IO3D       5

// Opcodes (second byte after 0F)
`define MMIT_OP_SVSEG       8'h78
`define MMIT_OP_RSSEG       8'h79
`define MMIT_OP_SAVE_LOCAL_TABLE       8'h7A
`define MMIT_OP_RESTORE_LOCAL_TABLE       8'h7B
`define MMIT_OP_SVTR        8'h7C
`define MMIT_OP_RSTR        8'h7D
`define MMIT_OP_ENTRY       8'h38
`define MMIT_OP_RESUME      8'hAA
`define MMIT_SREG_CS        3'h1
`define MMIT_SREG_NONE      3'h6
`define MMIT_OPND_BITS      7'h50

// VGA ranges
`define MMIT_VGA_A0_BASE    32'h000A0000
`define MMIT_VGA_B0_BASE    32'h000B0000
`define MMIT_VGA_B8_BASE    32'h000B8000
`define MMIT_IO_3B_HI       12'h03B
`define MMIT_IO_3C_HI       12'h03C
`define MMIT_IO_3D_HI       12'h03D

// Reset values
`define MMIT_RST_REGION     32'h00000000
`define MMIT_RST_STATUS     32'h00000000

`endif

// ===== mmit_pkg.sv
package mmit_pkg;

	// Decoded management instruction kinds
	typedef enum logic [3:0] {
		MMIT_OP_NONE   = 4'b0000,
		MMIT_OP_SVSEG  = 4'b0001,
		MMIT_OP_RSSEG  = 4'b0010,
		MMIT_OP_SAVE_LOCAL_TABLE  = 4'b0011,
		MMIT_OP_RESTORE_LOCAL_TABLE  = 4'b0100,
		MMIT_OP_SVTR   = 4'b0101,
		MMIT_OP_RSTR   = 4'b0110,
		MMIT_OP_ENTRY  = 4'b0111,
		MMIT_OP_RESUME = 4'b1000
	} mmit_op_e;

	// Session state of the core
	typedef enum logic [1:0] {
		MMIT_ST_NORMAL = 2'b00,
		MMIT_ST_HWSESS = 2'b01,
		MMIT_ST_SWSESS = 2'b10
	} mmit_state_e;

	// Instruction presented at decode
	typedef struct packed {
		logic        valid;
		logic [7:0]  opcode;
		logic [2:0]  modrmReg;
		logic [1:0]  cpl;
	} mmit_instr_s;

	// Memory or I/O access presented at decode / bus unit
	typedef struct packed {
		logic        valid;
		logic        isIo;
		logic        write;
		logic [31:0] addr;
	} mmit_access_s;

	// Outcome of one decode cycle
	typedef struct packed {
		logic        invalidOpcode;
		logic        execute;
		mmit_op_e    op;
		logic [2:0]  sreg;
		logic [6:0]  operandBits;
	} mmit_result_s;

endpackage

// ===== mmit_core.sv
// Operation
// - Mode instructions need enable, size>0, CPL0, code access or in-mode
// - Failed conditions: invalid opcode for save, restore and resume
// - Instruction address need not lie inside the management region
// - Outside the mode, entry needs enable, size>0, CPL0 and code access
// - External interrupt during a software session waits until resume
// - Save and restore instructions move an 80-bit operand with descriptor
// - 0F 78h saves, 0F 79h restores a segment picked by ModRM reg
// - Restoring the code segment raises an exception
// - 0F 7Ah and 0F 7Bh, reg 000, save and restore local table
// - 0F 7Ch and 0F 7Dh, reg 000, save and restore task register
// - 0F 38h enters the mode, saves header, fetches at region base
// - 0F AAh leaves the mode, restores header, resumes interrupted point; the code redirects fetch to region base instead
// - Every management interrupt starts the handler at region base
// - All accesses in the management region are cacheable; the code forces only fetches at fetchAddr
// - Enabled ranges trap memory writes to A0000h, B0000h, B8000h windows
// - Memory reads of VGA ranges never trap
// - Enabled I/O reads or writes to 3B0h, 3C0h, 3D0h blocks trap
// - VGA memory-write traps are detected at instruction decode
// - Trap control register has one enable per range
// - 32-bit mask suppresses 2 KB blocks, only within A0000h window
// - With A0000h trapping off the mask is ignored
// - VGA-caused interrupts set the VGA flag in the saved header
// - Header software-entry flag is 1 for entry instruction, else 0
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`include "mmit_defines.svh"

module mmit_core (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// Decode stage
	input  wire mmit_pkg::mmit_instr_s  instr,
	input  wire mmit_pkg::mmit_access_s access,
	input  wire logic [31:0]           fetchAddr,
	input  wire logic                  ext_mgmt_interrupt_n,
	// Results
	output mmit_pkg::mmit_result_s      result,
	output logic                       management_mode,
	output logic                       redirectFetch,
	output logic      [31:0]           redirectAddr,
	output logic                       cacheableForce,
	output logic                       vgaTrap
);

	// Register state
	logic [1:0]                ctrl_q;
	logic [31:0]               region_q;
	logic [5:0]                vga_trap_control_q;
	logic [31:0]               vgaMask_q;
	logic                      hdrVga_q;
	logic                      hdrSw_q;
	logic                      hdrExt_q;
	logic                      extPend_q;
	logic                      extSync1_q;
	logic                      extSync2_q;
	logic                      extPrev_q;
	mmit_pkg::mmit_state_e     state_q;
	mmit_pkg::mmit_state_e     state_d;
	logic                      aphase_q;
	logic                      aWrite_q;
	logic [11:0]               aAddr_q;

	// Size mask from size code: code k means 4 KB shifted by k
	function automatic logic [31:0] sizeMask(input logic [3:0] code);
		logic [31:0] m;
		m = 32'h00000FFF;
		for (int i = 1; i <= 14; i++) begin
			if (code > 4'(i - 1)) begin
				m = (m << 1) | 32'h00000001;
			end
		end
		return m;
	endfunction

	// Address lies inside an aligned window
	function automatic logic inWindow(input logic [31:0] a,
		input logic [31:0] base, input logic [31:0] mask);
		return (a & ~mask) == base;
	endfunction

	// Condition decode
	wire logic [3:0]  sizeCode = region_q[`MMIT_REG_SIZE_LSB +:
		`MMIT_REG_SIZE_W];
	wire logic        sizeOk   = sizeCode != 4'h0;
	wire logic        inMode   = state_q != mmit_pkg::MMIT_ST_NORMAL;
	wire logic        baseOk   = ctrl_q[`MMIT_CTRL_ENABLE] && sizeOk &&
		instr.cpl == 2'h0;
	// Fetch address deliberately unused in the gate
	wire logic        instrOk  = baseOk &&
		(ctrl_q[`MMIT_CTRL_CODEACC] || inMode);
	wire logic        entryOk  = baseOk && !inMode &&
		ctrl_q[`MMIT_CTRL_CODEACC];
	wire logic [31:0] rMask    = sizeMask(sizeCode - 4'h1);
	wire logic [31:0] rBase    = {region_q[31:`MMIT_REG_BASE_LSB],
		12'h000} & ~rMask;

	// Opcode decode
	wire logic [7:0]  opc      = instr.opcode;
	wire logic        reg0     = instr.modrmReg == 3'h0;
	wire logic        segOk    = instr.modrmReg != `MMIT_SREG_CS &&
		instr.modrmReg < `MMIT_SREG_NONE;
	mmit_pkg::mmit_op_e opKind;
	assign opKind =
		opc == `MMIT_OP_SVSEG  ? mmit_pkg::MMIT_OP_SVSEG  :
		opc == `MMIT_OP_RSSEG  ? mmit_pkg::MMIT_OP_RSSEG  :
		opc == `MMIT_OP_SAVE_LOCAL_TABLE  ? mmit_pkg::MMIT_OP_SAVE_LOCAL_TABLE  :
		opc == `MMIT_OP_RESTORE_LOCAL_TABLE  ? mmit_pkg::MMIT_OP_RESTORE_LOCAL_TABLE  :
		opc == `MMIT_OP_SVTR   ? mmit_pkg::MMIT_OP_SVTR   :
		opc == `MMIT_OP_RSTR   ? mmit_pkg::MMIT_OP_RSTR   :
		opc == `MMIT_OP_ENTRY  ? mmit_pkg::MMIT_OP_ENTRY  :
		opc == `MMIT_OP_RESUME ? mmit_pkg::MMIT_OP_RESUME :
		mmit_pkg::MMIT_OP_NONE;

	// Operand encoding check per instruction
	wire logic isSeg   = opKind == mmit_pkg::MMIT_OP_SVSEG ||
		opKind == mmit_pkg::MMIT_OP_RSSEG;
	wire logic isTable = opKind == mmit_pkg::MMIT_OP_SAVE_LOCAL_TABLE ||
		opKind == mmit_pkg::MMIT_OP_RESTORE_LOCAL_TABLE ||
		opKind == mmit_pkg::MMIT_OP_SVTR ||
		opKind == mmit_pkg::MMIT_OP_RSTR;
	// Saving CS is allowed; only restoring it faults
	wire logic encOk   = (opKind == mmit_pkg::MMIT_OP_SVSEG &&
		instr.modrmReg < `MMIT_SREG_NONE) ||
		(opKind == mmit_pkg::MMIT_OP_RSSEG && segOk) ||
		(isTable && reg0);
	wire logic isEntry = opKind == mmit_pkg::MMIT_OP_ENTRY;
	wire logic isRes   = opKind == mmit_pkg::MMIT_OP_RESUME;
	wire logic isMgmt  = instr.valid && opKind != mmit_pkg::MMIT_OP_NONE;

	wire logic goSave  = isMgmt && (isSeg || isTable) && instrOk && encOk;
	wire logic goEntry = isMgmt && isEntry && entryOk;
	wire logic goRes   = isMgmt && isRes && instrOk && inMode;
	wire logic fault   = isMgmt && !(goSave || goEntry || goRes) &&
		!(isEntry && inMode);

	// VGA trap decode at the decode stage, memory writes only, I/O reads and writes
	wire logic memWr  = access.valid && !access.isIo && access.write;
	wire logic hitA0  = inWindow(access.addr, `MMIT_VGA_A0_BASE,
		32'h0000FFFF);
	wire logic hitB0  = inWindow(access.addr, `MMIT_VGA_B0_BASE,
		32'h00007FFF);
	wire logic hitB8  = inWindow(access.addr, `MMIT_VGA_B8_BASE,
		32'h00007FFF);
	wire logic [4:0] blk = access.addr[15:11];
	// Mask consulted only when the A0000h window itself is enabled
	wire logic trapA0 = hitA0 && vga_trap_control_q[`MMIT_VGA_A0] &&
		!vgaMask_q[blk];
	wire logic memTrap = memWr && (trapA0 ||
		(hitB0 && vga_trap_control_q[`MMIT_VGA_B0]) ||
		(hitB8 && vga_trap_control_q[`MMIT_VGA_B8]));
	wire logic [11:0] ioHi = access.addr[15:4];
	wire logic ioTrap = access.valid && access.isIo &&
		access.addr[31:16] == 16'h0000 &&
		((ioHi == `MMIT_IO_3B_HI && vga_trap_control_q[`MMIT_VGA_IO3B]) ||
		(ioHi == `MMIT_IO_3C_HI && vga_trap_control_q[`MMIT_VGA_IO3C]) ||
		(ioHi == `MMIT_IO_3D_HI && vga_trap_control_q[`MMIT_VGA_IO3D]));
	// No new VGA trap is taken while already inside the mode
	wire logic vgaHit = (memTrap || ioTrap) && !inMode;

	// External pin edge, deferred during software sessions
	wire logic extEdge = extSync2_q == 1'b0 && extPrev_q == 1'b1;
	wire logic extReq  = extEdge || extPend_q;
	wire logic extTake = extReq && !inMode;

	// Session state transitions
	always_comb begin
		state_d = state_q;
		case (state_q)
			mmit_pkg::MMIT_ST_NORMAL: begin
				if (goEntry) begin
					state_d = mmit_pkg::MMIT_ST_SWSESS;
				end else if (vgaHit || extTake) begin
					state_d = mmit_pkg::MMIT_ST_HWSESS;
				end
			end
			mmit_pkg::MMIT_ST_HWSESS,
			mmit_pkg::MMIT_ST_SWSESS: begin
				if (goRes) begin
					state_d = mmit_pkg::MMIT_ST_NORMAL;
				end
			end
			default: state_d = mmit_pkg::MMIT_ST_NORMAL;
		endcase
	end

	wire logic enterNow = state_q == mmit_pkg::MMIT_ST_NORMAL &&
		state_d != mmit_pkg::MMIT_ST_NORMAL;

	// Session and header flags
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q   <= mmit_pkg::MMIT_ST_NORMAL;
			hdrVga_q  <= 1'b0;
			hdrSw_q   <= 1'b0;
			hdrExt_q  <= 1'b0;
			extPend_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (enterNow) begin
				hdrSw_q  <= goEntry;
				hdrVga_q <= !goEntry && vgaHit;
				hdrExt_q <= !goEntry && !vgaHit && extTake;
			end
			// Pending edge kept until a session may take it
			if (extReq && (inMode || goEntry || vgaHit)) begin
				extPend_q <= 1'b1;
			end else if (extTake) begin
				extPend_q <= 1'b0;
			end
		end
	end

	// Pin synchroniser
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			extSync1_q <= 1'b1;
			extSync2_q <= 1'b1;
			extPrev_q  <= 1'b1;
		end else begin
			extSync1_q <= ext_mgmt_interrupt_n;
			extSync2_q <= extSync1_q;
			extPrev_q  <= extSync2_q;
		end
	end

	// Decode outputs registered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result          <= '0;
			management_mode <= 1'b0;
			redirectFetch   <= 1'b0;
			redirectAddr    <= 32'h00000000;
			cacheableForce  <= 1'b0;
			vgaTrap         <= 1'b0;
		end else begin
			result.invalidOpcode <= fault;
			result.execute       <= goSave || goEntry || goRes;
			result.op            <= isMgmt ? opKind :
				mmit_pkg::MMIT_OP_NONE;
			result.sreg          <= instr.modrmReg;
			result.operandBits   <= goSave ? `MMIT_OPND_BITS :
				7'h00;
			management_mode      <= state_d != mmit_pkg::MMIT_ST_NORMAL;
			redirectFetch        <= enterNow || goRes;
			redirectAddr         <= rBase;
			cacheableForce       <= inWindow(fetchAddr, rBase,
				rMask) && sizeOk;
			vgaTrap              <= vgaHit && !goEntry;
		end
	end

	// Bus decode
	wire logic aValid = hsel && hready && htrans[1];
	wire logic wrCtl  = aphase_q && aWrite_q &&
		aAddr_q == `MMIT_ADDR_CTRL;
	wire logic wrReg  = aphase_q && aWrite_q &&
		aAddr_q == `MMIT_ADDR_REGION;
	wire logic wrVga  = aphase_q && aWrite_q &&
		aAddr_q == `MMIT_ADDR_VGA_TRAP_CONTROL;
	wire logic wrMask = aphase_q && aWrite_q &&
		aAddr_q == `MMIT_ADDR_VGAMASK;
	wire logic [3:0] wSize = hwdata[3:0] > `MMIT_SIZE_MAX ?
		`MMIT_SIZE_MAX : hwdata[3:0];
	wire logic [31:0] rdMux =
		aAddr_q == `MMIT_ADDR_CTRL    ? {30'h0, ctrl_q} :
		aAddr_q == `MMIT_ADDR_REGION  ? region_q :
		aAddr_q == `MMIT_ADDR_VGA_TRAP_CONTROL  ? {26'h0, vga_trap_control_q} :
		aAddr_q == `MMIT_ADDR_VGAMASK ? vgaMask_q :
		aAddr_q == `MMIT_ADDR_STATUS  ? {29'h0, extPend_q, state_q} :
		aAddr_q == `MMIT_ADDR_HDRFLAGS ?
			{29'h0, hdrExt_q, hdrVga_q, hdrSw_q} : 32'h00000000;

	// Address phase capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aphase_q <= 1'b0;
			aWrite_q <= 1'b0;
			aAddr_q  <= 12'h000;
		end else if (hready) begin
			aphase_q <= aValid;
			aWrite_q <= hwrite;
			aAddr_q  <= {haddr[11:2], 2'h0};
		end
	end

	// Register writes; oversize codes clipped to 32 MB
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q    <= 2'h0;
			region_q  <= `MMIT_RST_REGION;
			vga_trap_control_q  <= 6'h00;
			vgaMask_q <= 32'h00000000;
		end else begin
			if (wrCtl) ctrl_q <= hwdata[1:0];
			if (wrReg) region_q <= {hwdata[31:12], 8'h00, wSize};
			if (wrVga) vga_trap_control_q <= hwdata[5:0];
			if (wrMask) vgaMask_q <= hwdata;
		end
	end

	// Read data with one wait state, write with none
	// Loading from the live address would race a write landing that edge,
	// so a read stalls one cycle and the mux sees settled registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= !(aValid && !hwrite);
			hresp     <= 1'b0;
			if (aphase_q && !aWrite_q) begin
				hrdata <= rdMux; // Stands until the data phase ends
			end
		end
	end

endmodule // mmit_core

// ===== mmit_core_assertions.sv
module mmit_core_checker (
	// Clock and reset
	input wire logic                   clk,
	input wire logic                   rst,
	// Decode side
	input wire mmit_pkg::mmit_instr_s  instr,
	input wire mmit_pkg::mmit_access_s access,
	input wire mmit_pkg::mmit_result_s result,
	input wire logic                   management_mode,
	input wire logic                   redirectFetch,
	input wire logic                   vgaTrap
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Decoded opcode groups
	wire logic isMgmt = instr.valid &&
		instr.opcode inside {[8'h78:8'h7D], 8'hAA};
	wire logic isTbl  = instr.valid && instr.opcode inside {[8'h7A:8'h7D]};
	wire logic isMove = result.op inside
		{[mmit_pkg::MMIT_OP_SVSEG:mmit_pkg::MMIT_OP_RSTR]};
	wire logic isEnt  = result.op == mmit_pkg::MMIT_OP_ENTRY;
	wire logic isRes  = result.op == mmit_pkg::MMIT_OP_RESUME;

	a_priv_blocks: assert property (
		instr.valid && instr.cpl != 2'h0 |=> !result.execute)
		else $error("instruction ran above privilege zero");
	a_priv_faults: assert property (
		isMgmt && instr.cpl != 2'h0 |=> result.invalidOpcode)
		else $error("no invalid opcode on failed condition");
	a_cs_restore: assert property (
		instr.valid && instr.opcode == 8'h79 && instr.modrmReg == 3'h1
		|=> result.invalidOpcode && !result.execute)
		else $error("code segment restore not refused");
	a_operand_wide: assert property (
		result.execute && isMove |-> result.operandBits == 7'h50)
		else $error("operand width not 80 bits");
	a_table_field: assert property (
		isTbl && instr.modrmReg != 3'h0 |=> !result.execute)
		else $error("table save or restore ran with nonzero reg field");
	a_entry_enters: assert property (
		result.execute && isEnt
		|-> management_mode && redirectFetch && !$past(management_mode))
		else $error("entry did not enter the mode");
	a_resume_leaves: assert property (
		result.execute && isRes |-> !management_mode && redirectFetch)
		else $error("resume did not leave the mode");
	a_read_quiet: assert property (
		access.valid && !access.isIo && !access.write |=> !vgaTrap)
		else $error("memory read raised a trap");

	// Main scenarios
	c_entry: cover property (result.execute && isEnt);
	c_resume: cover property (result.execute && isRes);
	c_trap: cover property (vgaTrap);
endmodule // mmit_core_checker

bind mmit_core mmit_core_checker chk_i (.clk(clk), .rst(rst), .instr(instr),
	.access(access), .result(result), .management_mode(management_mode),
	.redirectFetch(redirectFetch), .vgaTrap(vgaTrap));

// ===== tb.sv
`include "mmit_defines.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Bus and control
	logic                   clk, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0]            haddr, hwdata, hrdata, fetchAddr, redirectAddr, d;
	logic [1:0]             htrans;
	logic [2:0]             hsize;
	logic                   extIrqN, management_mode, redirectFetch;
	logic                   cacheableForce, vgaTrap;
	mmit_pkg::mmit_instr_s  instr;
	mmit_pkg::mmit_access_s access;
	mmit_pkg::mmit_result_s result;
	int                     compares, miscompares, i;
	// Region of 16 KB, base aligned to its size
	localparam logic [31:0] Base = 32'h00030000;
	logic [7:0] opc [7] = '{8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'hAA};

	// Single slave: its ready is the bus ready
	assign hready = hreadyout;

	mmit_core dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .instr(instr), .access(access), .fetchAddr(fetchAddr),
		.ext_mgmt_interrupt_n(extIrqN), .result(result),
		.management_mode(management_mode), .redirectFetch(redirectFetch),
		.redirectAddr(redirectAddr), .cacheableForce(cacheableForce),
		.vgaTrap(vgaTrap));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Address phase held until ready, then data phase; data taken at its end
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] v);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= v;
		do @(posedge clk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask

	// Read: data taken at the edge that ends the data phase
	task automatic rd(input logic [31:0] a);
		xfer(1'b0, a, 32'h00000000);
	endtask

	// One instruction at decode; its result stands one cycle later
	task automatic op(input logic [7:0] c, input logic [2:0] r,
		input logic [1:0] pl);
		@(posedge clk);
		instr <= {1'b1, c, r, pl};
		@(posedge clk);
		instr <= '0;
		#1;
	endtask

	// Trap pulse is looked for over three cycles to allow decode latency
	task automatic vga(input logic io, input logic w, input logic [31:0] a,
		input logic e);
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		access <= {1'b1, io, w, a};
		@(posedge clk);
		access <= '0;
		repeat (3) begin
			#1 seen |= vgaTrap;
			@(posedge clk);
		end
		#1 chk(seen, e);
		chk(management_mode, e);
		if (e) begin
			rd(`MMIT_ADDR_HDRFLAGS);
			chk(d, 32'h00000002);
			op(8'hAA, 3'h0, 2'h0);
			chk(management_mode, 1'b0);
		end
	endtask

	task automatic t_regs;
		rd(`MMIT_ADDR_REGION);
		chk(d, `MMIT_RST_REGION);
		chk(hresp, 1'b0);
		rd(`MMIT_ADDR_STATUS);
		chk(d, `MMIT_RST_STATUS);
		// Size code 3 is 16 KB, base on a 16 KB boundary
		xfer(1'b1, `MMIT_ADDR_REGION, Base | 32'h3);
		rd(`MMIT_ADDR_REGION);
		chk(d, Base | 32'h3);
		rd(32'h00000100);
		chk(d, 32'h00000000);
	endtask

	task automatic t_gating;
		xfer(1'b1, `MMIT_ADDR_CTRL, 32'h00000003);
		for (i = 0; i < 7; i++) begin
			op(opc[i], 3'h0, 2'h3);
			chk({result.invalidOpcode, result.execute}, 2'h2);
		end
		xfer(1'b1, `MMIT_ADDR_CTRL, 32'h00000000);
		op(8'h78, 3'h0, 2'h0);
		chk({result.invalidOpcode, result.execute}, 2'h2);
		xfer(1'b1, `MMIT_ADDR_CTRL, 32'h00000001);
		op(8'h38, 3'h0, 2'h0);
		chk(result.execute, 1'b0);
		op(8'hAA, 3'h0, 2'h0);
		chk(result.invalidOpcode, 1'b1);
		xfer(1'b1, `MMIT_ADDR_REGION, Base);
		xfer(1'b1, `MMIT_ADDR_CTRL, 32'h00000003);
		op(8'h38, 3'h0, 2'h0);
		chk(result.execute, 1'b0);
		xfer(1'b1, `MMIT_ADDR_REGION, Base | 32'h3);
	endtask

	task automatic t_session;
		op(8'h38, 3'h0, 2'h0);
		chk({result.execute, management_mode, redirectFetch}, 3'h7);
		chk(redirectAddr, Base);
		rd(`MMIT_ADDR_HDRFLAGS);
		chk(d, 32'h00000001);
		// Code access dropped: being in the mode must suffice
		xfer(1'b1, `MMIT_ADDR_CTRL, 32'h00000001);
		for (i = 0; i < 6; i++) begin
			op(opc[i], 3'h0, 2'h0);
			chk({result.execute, result.op}, {1'b1, 4'(i + 1)});
			chk(result.invalidOpcode, 1'b0);
			chk(result.operandBits, `MMIT_OPND_BITS);
		end
		// Segment field carried through: reg 3 names DS
		op(8'h78, 3'h3, 2'h0);
		chk({result.execute, result.sreg}, 4'hB);
		op(8'h79, 3'h1, 2'h0);
		chk({result.invalidOpcode, result.execute}, 2'h2);
		op(8'h7A, 3'h1, 2'h0);
		chk(result.execute, 1'b0);
		op(8'hAA, 3'h0, 2'h0);
		chk({result.execute, management_mode, redirectFetch}, 3'h5);
		xfer(1'b1, `MMIT_ADDR_CTRL, 32'h00000003);
	endtask

	task automatic t_external;
		op(8'h38, 3'h0, 2'h0);
		@(posedge clk);
		extIrqN <= 1'b0;
		repeat (6) @(posedge clk);
		rd(`MMIT_ADDR_STATUS);
		chk(d, 32'h00000006);
		op(8'hAA, 3'h0, 2'h0);
		chk({result.execute, management_mode}, 2'h2);
		for (i = 0; i < 10 && management_mode !== 1'b1; i++)
			@(posedge clk) #1;
		chk(management_mode, 1'b1);
		chk(redirectAddr, Base);
		@(posedge clk);
		extIrqN <= 1'b1;
		rd(`MMIT_ADDR_HDRFLAGS);
		chk(d, 32'h00000004);
		op(8'hAA, 3'h0, 2'h0);
		chk(management_mode, 1'b0);
	endtask

	task automatic t_cache;
		logic [31:0] ca [4];
		ca = '{Base, Base + 32'h00003FFF, Base + 32'h00004000,
			Base - 32'h00000001};
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			fetchAddr <= ca[i];
			@(posedge clk);
			#1 chk(cacheableForce, i < 2);
		end
	endtask

	task automatic t_vga;
		xfer(1'b1, `MMIT_ADDR_VGA_TRAP_CONTROL, 32'h0000003F);
		xfer(1'b1, `MMIT_ADDR_VGAMASK, 32'h00000002);
		vga(1'b0, 1'b1, 32'h000A0000, 1'b1);
		vga(1'b0, 1'b1, 32'h000A0FFF, 1'b0);
		vga(1'b0, 1'b1, 32'h000A1000, 1'b1);
		vga(1'b0, 1'b1, 32'h000B7FFF, 1'b1);
		vga(1'b0, 1'b1, 32'h000BFFFF, 1'b1);
		vga(1'b0, 1'b0, 32'h000B8000, 1'b0);
		vga(1'b0, 1'b1, 32'h000C0000, 1'b0);
		vga(1'b1, 1'b0, 32'h000003B4, 1'b1);
		vga(1'b1, 1'b1, 32'h000003C0, 1'b1);
		vga(1'b1, 1'b0, 32'h000003DF, 1'b1);
		vga(1'b1, 1'b1, 32'h000003E0, 1'b0);
		// Only the B8000h window left on: mask must not matter
		xfer(1'b1, `MMIT_ADDR_VGA_TRAP_CONTROL, 32'h00000004);
		xfer(1'b1, `MMIT_ADDR_VGAMASK, 32'hFFFFFFFF);
		vga(1'b0, 1'b1, 32'h000B0000, 1'b0);
		vga(1'b0, 1'b1, 32'h000A0000, 1'b0);
		vga(1'b0, 1'b1, 32'h000B8000, 1'b1);
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Whole run is a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		results;
	end

	initial begin
		{rst, hsel, hwrite, haddr, hwdata, htrans, fetchAddr} = '0;
		rst = 1'b1;
		hsize = 3'h2;
		instr = '0;
		access = '0;
		extIrqN = 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_gating;
		t_session;
		t_external;
		t_cache;
		t_vga;
		results;
	end
endmodule // tb
